/* File: rtl/sfs_host.sv */
`timescale 1ns/1ps
module sfs_host #(
  parameter int HALF_CYC = sfs_pkg::HALF_BENCH_CYC
) (
  // clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        rstn_i,
  // link
  sfs_if.host              link,
  // command
  input  wire logic        start_i,
  input  wire logic [7:0]  op_i,
  input  wire logic [23:0] addr_i,
  input  wire logic [11:0] len_i,
  input  wire logic        mode3_i,
  output logic             busy_o,
  output logic             done_o,
  // write bytes
  input  wire logic [7:0]  wr_data_i,
  input  wire logic        wr_valid_i,
  output logic             wr_ready_o,
  // read bytes
  output logic      [7:0]  rd_data_o,
  output logic             rd_valid_o
);
  typedef enum logic [2:0] {
    SFS_IDLE, SFS_LEAD, SFS_RUN, SFS_TAIL, SFS_GAP
  } sfs_hstate_t;

  sfs_hstate_t st_q;
  logic        miso_s1_q, miso_s2_q;
  logic        sck_q, cs_n_q, mosi_q, prst_n_q;
  logic [7:0]  op_q;
  logic [23:0] addr_q;
  logic [15:0] div_q;
  logic [15:0] half_q;
  logic [15:0] rise_q;
  logic [15:0] total_q;
  logic [15:0] rd_lo_q;
  logic [15:0] rd_hi_q;
  logic [7:0]  tx_q;
  logic [7:0]  rsh_q;
  logic        is_rd_q;
  logic [15:0] nb;
  logic [12:0] bidx;
  logic        need_wr;
  logic        tick;
  logic [15:0] cidx;
  logic [3:0]  hdr_i;

  function automatic logic [15:0] half_of(input logic [7:0] op);
    int lim;
    lim = (op == sfs_pkg::OP_ARRAY_LOW) ? sfs_pkg::HALF_LOW_CYC
                                        : sfs_pkg::HALF_MIN_CYC;
    return 16'((HALF_CYC > lim) ? HALF_CYC : lim);
  endfunction

  assign hdr_i   = sfs_pkg::hdr_len(op_i);
  assign nb      = rise_q + 16'h0001;
  assign bidx    = nb[15:3];
  assign need_wr = !is_rd_q && (nb[2:0] == 3'h0) && (nb < total_q) &&
                   (bidx >= 13'(sfs_pkg::WR_HDR_BYTES));
  assign tick    = (div_q == half_q - 16'h0001);
  assign cidx    = rise_q - rd_lo_q - 16'h0001;

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      miso_s1_q <= 1'b0;
      miso_s2_q <= 1'b0;
      prst_n_q  <= 1'b0;
    end else begin
      miso_s1_q <= link.miso;
      miso_s2_q <= miso_s1_q;
      // release flash reset only once select is high
      prst_n_q  <= prst_n_q | cs_n_q;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_q <= SFS_IDLE;
      sck_q <= 1'b0;
      cs_n_q <= 1'b1;
      mosi_q <= 1'b0;
      op_q <= '0;
      addr_q <= '0;
      div_q <= '0;
      half_q <= 16'h0001;
      rise_q <= '0;
      total_q <= '0;
      rd_lo_q <= '0;
      rd_hi_q <= '0;
      tx_q <= '0;
      rsh_q <= '0;
      is_rd_q <= 1'b0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      wr_ready_o <= 1'b0;
      rd_data_o <= '0;
      rd_valid_o <= 1'b0;
    end else begin
      done_o     <= 1'b0;
      wr_ready_o <= 1'b0;
      rd_valid_o <= 1'b0;
      case (st_q)
        SFS_IDLE: begin
          // idle level is set while select is still high
          sck_q <= mode3_i;
          if (start_i && prst_n_q) begin
            op_q    <= op_i;
            addr_q  <= addr_i;
            half_q  <= half_of(op_i);
            is_rd_q <= (hdr_i != 4'h0);
            rd_lo_q <= {9'h000, hdr_i, 3'h0};
            rd_hi_q <= {9'h000, hdr_i, 3'h0} + {1'b0, len_i, 3'h0};
            total_q <= (hdr_i != 4'h0)
                       ? {9'h000, hdr_i, 3'h0} + {1'b0, len_i, 3'h0}
                       : {9'h000, sfs_pkg::WR_HDR_BYTES, 3'h0} +
                         {1'b0, len_i, 3'h0};
            mosi_q  <= op_i[7];
            tx_q    <= {op_i[6:0], 1'b0};
            rise_q  <= '0;
            div_q   <= '0;
            busy_o  <= 1'b1;
            st_q    <= SFS_LEAD;
          end
        end
        SFS_LEAD: begin
          // select falls a cycle after the idle level settled
          cs_n_q <= 1'b0;
          div_q <= div_q + 16'h0001;
          if (tick) begin
            div_q <= '0;
            st_q  <= SFS_RUN;
          end
        end
        SFS_RUN: begin
          if (!tick) begin
            div_q <= div_q + 16'h0001;
          end else if (rise_q == total_q && !sck_q) begin
            div_q <= '0;
            st_q  <= SFS_TAIL;
          end else if (!sck_q && need_wr && !wr_valid_i) begin
            div_q <= div_q; // stall clock until a write byte arrives
          end else begin
            div_q <= '0;
            sck_q <= ~sck_q;
            if (!sck_q) begin
              rise_q <= nb;
              if (nb[2:0] != 3'h0) begin
                mosi_q <= tx_q[7];
                tx_q   <= {tx_q[6:0], 1'b0};
              end else if (need_wr) begin
                mosi_q     <= wr_data_i[7];
                tx_q       <= {wr_data_i[6:0], 1'b0};
                wr_ready_o <= 1'b1;
              end else begin
                case (bidx)
                  13'h0001: tx_q <= {addr_q[22:16], 1'b0};
                  13'h0002: tx_q <= {addr_q[14:8], 1'b0};
                  13'h0003: tx_q <= {addr_q[6:0], 1'b0};
                  default:  tx_q <= 8'h00;
                endcase
                case (bidx)
                  13'h0001: mosi_q <= addr_q[23];
                  13'h0002: mosi_q <= addr_q[15];
                  13'h0003: mosi_q <= addr_q[7];
                  default:  mosi_q <= 1'b0;
                endcase
              end
            end else if (is_rd_q && rise_q > rd_lo_q &&
                         rise_q <= rd_hi_q) begin
              // capture one full period after the device launched
              rsh_q <= {rsh_q[6:0], miso_s2_q};
              if (cidx[2:0] == 3'h7) begin
                rd_data_o  <= {rsh_q[6:0], miso_s2_q};
                rd_valid_o <= 1'b1;
              end
            end
          end
        end
        SFS_TAIL: begin
          div_q <= div_q + 16'h0001;
          if (tick) begin
            div_q  <= '0;
            cs_n_q <= 1'b1;
            st_q   <= SFS_GAP;
          end
        end
        default: begin
          div_q <= div_q + 16'h0001;
          if (div_q >= 16'(sfs_pkg::CS_HIGH_CYC - 1)) begin
            div_q  <= '0;
            busy_o <= 1'b0;
            done_o <= 1'b1;
            st_q   <= SFS_IDLE;
          end
        end
      endcase
    end
  end

  assign link.cs_n  = cs_n_q;
  assign link.sck   = sck_q;
  assign link.mosi  = mosi_q;
  assign link.rst_n = prst_n_q;
endmodule

/* File: rtl/sfs_pkg.sv */
package sfs_pkg;

  // command codes
  localparam logic [7:0] OP_ARRAY_LEGACY = 8'he8;
  localparam logic [7:0] OP_ARRAY_STD    = 8'h0b;
  localparam logic [7:0] OP_ARRAY_LOW    = 8'h03;
  localparam logic [7:0] OP_PAGE_READ    = 8'hd2;
  localparam logic [7:0] OP_PROT_READ    = 8'h32;
  localparam logic [7:0] OP_LOCK_READ    = 8'h35;
  localparam logic [7:0] OP_SEC_READ     = 8'h77;
  localparam logic [7:0] OP_STATUS_READ  = 8'hd7;
  localparam logic [7:0] OP_ID_READ      = 8'h9f;

  // page sizes
  localparam logic [8:0] PAGE_STD_BYTES = 9'h108;
  localparam logic [8:0] PAGE_ALT_BYTES = 9'h100;

  // status byte layout
  localparam int STAT_READY_BIT = 7;
  localparam int STAT_PAGE_BIT  = 0;

  // header bytes of a write-type frame: opcode and three address bytes
  localparam logic [3:0] WR_HDR_BYTES = 4'h4;

  // timing
  localparam int CLK_MHZ        = 100;
  localparam int SCK_MAX_MHZ    = 66;
  localparam int SCK_LOW_MHZ    = 33;
  localparam int CS_HIGH_NS     = 50;
  localparam int HALF_MIN_CYC   = (CLK_MHZ + 2 * SCK_MAX_MHZ - 1) /
                                  (2 * SCK_MAX_MHZ);
  localparam int HALF_LOW_CYC   = (CLK_MHZ + 2 * SCK_LOW_MHZ - 1) /
                                  (2 * SCK_LOW_MHZ);
  localparam int CS_HIGH_CYC    = (CS_HIGH_NS * CLK_MHZ + 999) / 1000;
  localparam int HALF_BENCH_CYC = 4;

  // bytes before read data: opcode, address, dummy; zero for no read
  function automatic logic [3:0] hdr_len(input logic [7:0] op);
    logic [3:0] n;
    n = 4'h0;
    if (op == OP_ARRAY_LEGACY || op == OP_PAGE_READ) begin
      n = 4'h8;
    end else if (op == OP_ARRAY_STD) begin
      n = 4'h5;
    end else if (op == OP_ARRAY_LOW || op == OP_PROT_READ ||
                 op == OP_LOCK_READ || op == OP_SEC_READ) begin
      n = 4'h4;
    end else if (op == OP_STATUS_READ || op == OP_ID_READ) begin
      n = 4'h1;
    end
    return n;
  endfunction

endpackage

/* File: rtl/sfs_if.sv */
`timescale 1ns/1ps
interface sfs_if;
  logic cs_n;
  logic sck;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic rst_n;

  modport dev (
    input  cs_n,
    input  sck,
    input  mosi,
    input  rst_n,
    output miso,
    output miso_oe
  );

  modport host (
    output cs_n,
    output sck,
    output mosi,
    output rst_n,
    input  miso,
    input  miso_oe
  );
endinterface

/* File: rtl/sfs_fifo.sv */
`timescale 1ns/1ps
module sfs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             rstn_i,
  // fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wp_q;
  logic [AW-1:0]    rp_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             push;
  logic             pop;

  // ready is a flop, worked out from the next count
  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + (AW+1)'(1);
    end else if (pop && !push) begin
      cnt_d = cnt_q - (AW+1)'(1);
    end
  end
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rp_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_q[wp_q] <= in_data_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q      <= '0;
      in_ready_o <= 1'b1;
    end else begin
      if (push) begin
        wp_q <= (wp_q == LAST) ? '0 : wp_q + AW'(1);
      end
      if (pop) begin
        rp_q <= (rp_q == LAST) ? '0 : rp_q + AW'(1);
      end
      cnt_q      <= cnt_d;
      in_ready_o <= (cnt_d != FULL_CNT);
    end
  end
endmodule

/* File: rtl/sfs_dev.sv */
`timescale 1ns/1ps
// Function
// - shift out on fall, sample on rise
// - host captures at following falling edge
// - host launches bits on rising edge
// - idle-low and idle-high clock both accepted
// - output bit held through clock high phase
// - host clock never above 66 MHz
// - host keeps select high before reset release
// - decode three continuous array read codes
// - decode direct main page read code
// - decode protection, lockdown, security reads
// - decode status and identification reads
// - host rewrites each page within 10,000 ops
// - host rewrites at its page pointer
// - host programs direct or through buffer
// - page size 264 default, 256 selectable
// - low-frequency read clock at most 33 MHz
module sfs_dev #(
  parameter logic [31:0] ID_BYTES   = 32'h5a_a5_01_00, // arbitrary
  parameter logic [5:0]  STAT_MID   = 6'h00,
  parameter int          FIFO_DEPTH = 8
) (
  // clock and reset
  input  wire logic       core_clk_i,
  input  wire logic       rstn_i,
  // link
  sfs_if.dev              link,
  // page size strap and reconfigure
  input  wire logic       page_256_strap_i,
  input  wire logic       page_256_set_i,
  output logic            page_256_o,
  output logic      [8:0] page_bytes_o,
  // read data from user
  input  wire logic [7:0] rd_data_i,
  input  wire logic       rd_valid_i,
  output logic            rd_ready_o,
  // command and received bytes to user
  output logic      [7:0] cmd_o,
  output logic            cmd_valid_o,
  output logic      [7:0] rx_data_o,
  output logic            rx_valid_o,
  output logic            frame_o
);
  logic        cs_s1_q, cs_s2_q;
  logic        pr_s1_q, pr_s2_q;
  logic        sck_s1_q, sck_s2_q, sck_s3_q;
  logic        mosi_s1_q, mosi_s2_q, mosi_s3_q;
  logic        active;
  logic        rise;
  logic        fall;
  logic [15:0] bit_q;
  logic [7:0]  sh_q;
  logic [7:0]  sh_d;
  logic [7:0]  op_q;
  logic [3:0]  hdr;
  logic [15:0] hdr_bits;
  logic        rd_phase;
  logic [15:0] pos;
  logic        load;
  logic        from_fifo;
  logic [7:0]  out_q;
  logic [7:0]  nbyte;
  logic [15:0] obyte_q;
  logic        miso_q;
  logic        oe_q;
  logic        strap_done_q;
  logic        fifo_valid;
  logic [7:0]  fifo_data;

  // pin synchronisers
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      cs_s1_q   <= 1'b1;
      cs_s2_q   <= 1'b1;
      pr_s1_q   <= 1'b0;
      pr_s2_q   <= 1'b0;
      sck_s1_q  <= 1'b0;
      sck_s2_q  <= 1'b0;
      sck_s3_q  <= 1'b0;
      mosi_s1_q <= 1'b0;
      mosi_s2_q <= 1'b0;
      mosi_s3_q <= 1'b0;
    end else begin
      cs_s1_q   <= link.cs_n;
      cs_s2_q   <= cs_s1_q;
      pr_s1_q   <= link.rst_n;
      pr_s2_q   <= pr_s1_q;
      sck_s1_q  <= link.sck;
      sck_s2_q  <= sck_s1_q;
      sck_s3_q  <= sck_s2_q;
      mosi_s1_q <= link.mosi;
      mosi_s2_q <= mosi_s1_q;
      mosi_s3_q <= mosi_s2_q;
    end
  end

  // edges count only while selected and out of reset
  assign active = ~cs_s2_q & pr_s2_q;
  // either idle level at select works, edges alone drive the logic
  assign rise   = active & sck_s2_q & ~sck_s3_q;
  assign fall   = active & ~sck_s2_q & sck_s3_q;
  // mosi_s3 is the level before a change made with the rising edge
  assign sh_d   = {sh_q[6:0], mosi_s3_q};

  // command decode
  assign hdr      = sfs_pkg::hdr_len(op_q);
  assign hdr_bits = {9'h000, hdr, 3'h0};
  assign rd_phase = (bit_q >= 16'h0008) && (hdr != 4'h0) &&
                    (bit_q >= hdr_bits);
  assign pos       = bit_q - hdr_bits;
  assign load      = fall & rd_phase & (pos[2:0] == 3'h0);
  assign from_fifo = (op_q != sfs_pkg::OP_STATUS_READ) &&
                     (op_q != sfs_pkg::OP_ID_READ);

  // source of the next outgoing byte
  always_comb begin
    nbyte = 8'hff;
    if (op_q == sfs_pkg::OP_STATUS_READ) begin
      nbyte = {1'b1, STAT_MID, page_256_o};
    end else if (op_q == sfs_pkg::OP_ID_READ) begin
      case (obyte_q[1:0])
        2'h0:    nbyte = ID_BYTES[31:24];
        2'h1:    nbyte = ID_BYTES[23:16];
        2'h2:    nbyte = ID_BYTES[15:8];
        default: nbyte = ID_BYTES[7:0];
      endcase
    end else if (fifo_valid) begin
      nbyte = fifo_data;
    end
  end

  sfs_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i  (core_clk_i),
    .rstn_i      (rstn_i),
    .in_valid_i  (rd_valid_i),
    .in_ready_o  (rd_ready_o),
    .in_data_i   (rd_data_i),
    .out_valid_o (fifo_valid),
    .out_ready_i (load & from_fifo),
    .out_data_o  (fifo_data)
  );

  // input shifting and command capture
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      bit_q       <= '0;
      sh_q        <= '0;
      op_q        <= '0;
      cmd_o       <= '0;
      cmd_valid_o <= 1'b0;
      rx_data_o   <= '0;
      rx_valid_o  <= 1'b0;
    end else begin
      cmd_valid_o <= 1'b0;
      rx_valid_o  <= 1'b0;
      if (!active) begin
        bit_q <= '0;
        op_q  <= '0;
      end else if (rise) begin
        sh_q  <= sh_d;
        bit_q <= bit_q + 16'h0001;
        if (bit_q[2:0] == 3'h7) begin
          if (bit_q[15:3] == 13'h0000) begin
            op_q        <= sh_d;
            cmd_o       <= sh_d;
            cmd_valid_o <= 1'b1;
          end else begin
            rx_data_o  <= sh_d;
            rx_valid_o <= 1'b1;
          end
        end
      end
    end
  end

  // output shifting on falling edges
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      out_q   <= '0;
      obyte_q <= '0;
      miso_q  <= 1'b0;
      oe_q    <= 1'b0;
    end else begin
      if (!active) begin
        obyte_q <= '0;
        oe_q    <= 1'b0;
      end else if (load) begin
        miso_q  <= nbyte[7];
        out_q   <= {nbyte[6:0], 1'b0};
        obyte_q <= obyte_q + 16'h0001;
        oe_q    <= 1'b1;
      end else if (fall && rd_phase) begin
        miso_q <= out_q[7];
        out_q  <= {out_q[6:0], 1'b0};
      end
    end
  end

  // page size: strap caught after reset release, user may set 256
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      strap_done_q <= 1'b0;
      page_256_o   <= 1'b0;
      page_bytes_o <= sfs_pkg::PAGE_STD_BYTES;
    end else begin
      strap_done_q <= 1'b1;
      if (!strap_done_q) begin
        page_256_o   <= page_256_strap_i;
        page_bytes_o <= page_256_strap_i ? sfs_pkg::PAGE_ALT_BYTES
                                         : sfs_pkg::PAGE_STD_BYTES;
      end else if (page_256_set_i) begin
        page_256_o   <= 1'b1;
        page_bytes_o <= sfs_pkg::PAGE_ALT_BYTES;
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      frame_o <= 1'b0;
    end else begin
      frame_o <= active;
    end
  end

  assign link.miso    = miso_q;
  assign link.miso_oe = oe_q;
endmodule

/* File: dv/sfs_link_checker.sv */
`timescale 1ns/1ps
module sfs_link_checker #(
  parameter int HALF_CYC = 4
) (
  // clock and reset
  input  wire logic core_clk_i,
  input  wire logic rstn_i,
  // link
  input  wire logic cs_n,
  input  wire logic sck,
  input  wire logic mosi,
  input  wire logic miso,
  input  wire logic miso_oe,
  input  wire logic rst_n
);
  logic       sck_q;
  logic [7:0] sck_age_q;
  logic [7:0] fall_age_q;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  // previous clock level
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sck_q <= 1'b0;
    end else begin
      sck_q <= sck;
    end
  end

  // cycles since any clock change
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sck_age_q <= 8'hff;
    end else if (sck != sck_q) begin
      sck_age_q <= 8'h00;
    end else if (sck_age_q != 8'hff) begin
      sck_age_q <= sck_age_q + 8'h01;
    end
  end

  // cycles since falling clock
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fall_age_q <= 8'hff;
    end else if (sck_q && !sck) begin
      fall_age_q <= 8'h00;
    end else if (fall_age_q != 8'hff) begin
      fall_age_q <= fall_age_q + 8'h01;
    end
  end

  a_miso_after_fall: assert property (
    miso_oe && $past(miso_oe) && $changed(miso) |-> fall_age_q <= 8'h04)
    else $error("data out moved away from falling clock");
  a_mosi_on_rise: assert property (
    !cs_n && $past(!cs_n) && $changed(mosi) |-> $rose(sck))
    else $error("data in launched off rising clock");
  a_sck_still_start: assert property (
    $fell(cs_n) |-> $stable(sck) [*3])
    else $error("clock moved right after select fell");
  a_miso_low_phase: assert property (
    miso_oe && $past(miso_oe) && $changed(miso) |-> !$past(sck))
    else $error("data out changed in clock high phase");
  a_sck_half_min: assert property (
    (sck != sck_q) && !cs_n |-> sck_age_q >= 8'(HALF_CYC - 1))
    else $error("clock half period too short");
  a_rst_sel_order: assert property (
    $rose(rst_n) |-> cs_n && $past(cs_n))
    else $error("flash reset released with select low");
  a_sel_gap_min: assert property (
    $rose(cs_n) |-> cs_n [*5])
    else $error("select high gap too short");
  a_oe_release: assert property (
    $rose(cs_n) |-> ##[0:5] !miso_oe)
    else $error("output driven after deselect");

  c_mode0: cover property ($fell(cs_n) && !sck);
  c_mode3: cover property ($fell(cs_n) && sck);
  c_drive: cover property ($rose(miso_oe));
endmodule

/* File: dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
  localparam logic [31:0] ID_VAL = 32'h3c_c3_02_11; // arbitrary value
  logic        core_clk_i = 1'b0;
  logic        rstn_i     = 1'b0;
  logic        start_i    = 1'b0;
  logic [7:0]  op_i       = 8'h00;
  logic [23:0] addr_i     = 24'h00_0000;
  logic [11:0] len_i      = 12'h000;
  logic        mode3_i    = 1'b0;
  logic [7:0]  wr_data_i  = 8'h00;
  logic        wr_valid_i = 1'b0;
  logic        set_256    = 1'b0;
  logic        strap      = 1'b0;
  logic [7:0]  f_data     = 8'h00;
  logic        f_valid    = 1'b0;
  logic        done_o, wr_ready_o, rd_valid_o, f_ready;
  logic        cmd_valid_o, rx_valid_o, page_256, busy, frame;
  logic [7:0]  rd_data_o, cmd_o, rx_data_o;
  logic [8:0]  page_bytes_o;
  logic [7:0]  rd_q[$], rx_q[$], cmd_q[$];
  int          mismatches = 0;
  int          n_checks   = 0;

  sfs_if link_if ();
  sfs_dev #(.ID_BYTES(ID_VAL)) sfs_dev_inst (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .link(link_if.dev),
    .page_256_strap_i(strap), .page_256_set_i(set_256),
    .page_256_o(page_256),
    .page_bytes_o(page_bytes_o), .rd_data_i(f_data),
    .rd_valid_i(f_valid), .rd_ready_o(f_ready), .cmd_o(cmd_o),
    .cmd_valid_o(cmd_valid_o), .rx_data_o(rx_data_o),
    .rx_valid_o(rx_valid_o), .frame_o(frame));
  sfs_host sfs_host_inst (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .link(link_if.host),
    .start_i(start_i), .op_i(op_i), .addr_i(addr_i), .len_i(len_i),
    .mode3_i(mode3_i), .busy_o(busy), .done_o(done_o),
    .wr_data_i(wr_data_i), .wr_valid_i(wr_valid_i),
    .wr_ready_o(wr_ready_o), .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o));
  sfs_link_checker #(.HALF_CYC(sfs_pkg::HALF_BENCH_CYC))
    sfs_link_checker_inst (
    .core_clk_i(core_clk_i), .rstn_i(rstn_i), .cs_n(link_if.cs_n),
    .sck(link_if.sck), .mosi(link_if.mosi), .miso(link_if.miso),
    .miso_oe(link_if.miso_oe), .rst_n(link_if.rst_n));

  always #5 core_clk_i = ~core_clk_i;

  // collect received bytes
  always @(posedge core_clk_i) begin
    if (rd_valid_o === 1'b1) rd_q.push_back(rd_data_o);
    if (rx_valid_o === 1'b1) rx_q.push_back(rx_data_o);
    if (cmd_valid_o === 1'b1) cmd_q.push_back(cmd_o);
  end

  task automatic fail(input string msg);
    $display("ERROR %0t %s", $time, msg);
    mismatches++;
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) fail($sformatf("byte got %h exp %h", got, exp));
  endtask

  task automatic chk_cnt(input logic [8:0] got, input logic [8:0] exp);
    n_checks++;
    if (got !== exp) fail($sformatf("value got %h exp %h", got, exp));
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // wait for done (0) or write ready (1)
  task automatic wait_hi(input int sel);
    int k;
    k = 0;
    do begin
      @(posedge core_clk_i);
      k++;
    end while ((sel ? wr_ready_o : done_o) !== 1'b1 && k < 20000);
    if (k >= 20000) fail("handshake timed out");
  endtask

  task automatic fill(input int n, input logic [7:0] base);
    for (int j = 0; j < n; j++) begin
      f_data  <= base + 8'(j);
      f_valid <= 1'b1;
      @(posedge core_clk_i);
    end
    f_valid <= 1'b0;
  endtask

  task automatic do_frame(input logic [7:0] op, input logic [23:0] a,
                          input logic [11:0] n, input logic m3);
    rd_q.delete();
    rx_q.delete();
    cmd_q.delete();
    @(posedge core_clk_i);
    op_i    <= op;
    addr_i  <= a;
    len_i   <= n;
    mode3_i <= m3;
    start_i <= 1'b1;
    @(posedge core_clk_i);
    start_i <= 1'b0;
    wait_hi(0);
    chk_cnt({7'h00, busy, frame}, 9'h000);
  endtask

  task automatic chk_hdr(input logic [7:0] op, input logic [23:0] a);
    chk_byte(cmd_q[0], op);
    for (int i = 0; i < 3; i++) chk_byte(rx_q[i], a[23-8*i -: 8]);
  endtask

  task automatic t_status();
    chk_cnt(page_bytes_o, sfs_pkg::PAGE_STD_BYTES);
    for (int m = 0; m < 2; m++) begin
      do_frame(sfs_pkg::OP_STATUS_READ, 24'h0, 12'h001, m[0]);
      chk_byte(cmd_q[0], sfs_pkg::OP_STATUS_READ);
      chk_byte(rd_q[0], 8'h80);
    end
    @(posedge core_clk_i);
    set_256 <= 1'b1;
    @(posedge core_clk_i);
    set_256 <= 1'b0;
    do_frame(sfs_pkg::OP_STATUS_READ, 24'h0, 12'h001, 1'b0);
    chk_cnt(page_bytes_o, sfs_pkg::PAGE_ALT_BYTES);
    chk_cnt({8'h00, page_256}, 9'h001);
    chk_byte(rd_q[0], {1'b1, 6'h00, 1'b1});
  endtask

  task automatic t_ident();
    do_frame(sfs_pkg::OP_ID_READ, 24'h0, 12'h004, 1'b1);
    for (int j = 0; j < 4; j++) chk_byte(rd_q[j], ID_VAL[31-8*j -: 8]);
  endtask

  task automatic t_reads();
    logic [7:0] ops[7];
    ops = '{sfs_pkg::OP_ARRAY_LEGACY, sfs_pkg::OP_ARRAY_STD,
            sfs_pkg::OP_ARRAY_LOW, sfs_pkg::OP_PAGE_READ,
            sfs_pkg::OP_PROT_READ, sfs_pkg::OP_LOCK_READ,
            sfs_pkg::OP_SEC_READ};
    for (int i = 0; i < 7; i++) begin
      fill(3, 8'(16 * i));
      do_frame(ops[i], 24'h0a_b0_c0 + 24'(i), 12'h003, i[0]);
      chk_hdr(ops[i], 24'h0a_b0_c0 + 24'(i));
      for (int j = 0; j < 3; j++) chk_byte(rd_q[j], 8'(16 * i + j));
    end
  endtask

  task automatic t_fifo();
    fill(8, 8'h40);
    @(posedge core_clk_i);
    #1;
    chk_cnt({8'h00, f_ready}, 9'h000);
    do_frame(sfs_pkg::OP_ARRAY_STD, 24'h00_0100, 12'h009, 1'b0);
    for (int j = 0; j < 8; j++) chk_byte(rd_q[j], 8'h40 + 8'(j));
    chk_byte(rd_q[8], 8'hff);
    chk_cnt(9'(rd_q.size()), 9'h009);
    chk_cnt({8'h00, f_ready}, 9'h001);
  endtask

  task automatic t_write();
    fork
      do_frame(8'h82, 24'h01_02_03, 12'h002, 1'b0);
      begin
        repeat (40) @(posedge core_clk_i);
        chk_cnt({7'h00, busy, frame}, 9'h003);
        for (int j = 0; j < 2; j++) begin
          wr_data_i  <= 8'hc5 + 8'(j);
          wr_valid_i <= 1'b1;
          wait_hi(1);
        end
        wr_valid_i <= 1'b0;
      end
    join
    chk_hdr(8'h82, 24'h01_02_03);
    chk_byte(rx_q[3], 8'hc5);
    chk_byte(rx_q[4], 8'hc6);
  endtask

  task automatic t_reset();
    @(posedge core_clk_i);
    op_i    <= sfs_pkg::OP_ARRAY_LEGACY;
    len_i   <= 12'h004;
    start_i <= 1'b1;
    @(posedge core_clk_i);
    start_i <= 1'b0;
    repeat (60) @(posedge core_clk_i);
    rstn_i <= 1'b0;
    strap  <= 1'b1;
    @(posedge core_clk_i);
    #1;
    chk_cnt({8'h00, link_if.cs_n}, 9'h001);
    chk_cnt(page_bytes_o, sfs_pkg::PAGE_STD_BYTES);
    @(posedge core_clk_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    do_frame(sfs_pkg::OP_STATUS_READ, 24'h0, 12'h001, 1'b1);
    chk_byte(cmd_q[0], sfs_pkg::OP_STATUS_READ);
    chk_byte(rd_q[0], 8'h81);
    chk_cnt(page_bytes_o, sfs_pkg::PAGE_ALT_BYTES);
  endtask

  initial begin
    repeat (16) @(posedge core_clk_i);
    rstn_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    t_status();
    t_ident();
    t_reads();
    t_fifo();
    t_write();
    t_reset();
    test_done();
  end

  initial begin
    #800_000;
    fail("watchdog expired");
    test_done();
  end
endmodule
